// ===== core/tms_params.svh
// Constants of the timer master/slave synchronisation block
`ifndef TMS_PARAMS_SVH
`define TMS_PARAMS_SVH

// Counter width that the reload value carries
`define TMS_CNT_WIDTH 16
// Select field widths
`define TMS_SEL_WIDTH 3
`define TMS_TRS_WIDTH 4
// Trigger source codes
`define TMS_TRS_SOFTWARE 4'h0
`define TMS_TRS_CHAN0_FILT 4'h1
`define TMS_TRS_CHAN1_FILT 4'h2
`define TMS_TRS_EXT_TRIG 4'h3
`define TMS_TRS_CHAN0_EDGE 4'h8
`define TMS_TRS_INTERNAL0 4'h9
`define TMS_TRS_INTERNAL1 4'hA
`define TMS_TRS_INTERNAL2 4'hB
// Reload value used when counting up
`define TMS_RELOAD_ZERO 16'h0000
// Reset value of every state bit
`define TMS_STATE_RESET '0

`endif

// ===== core/tms_pkg.sv
// Types of the timer master/slave synchronisation block
`default_nettype none
`include "tms_params.svh"

package tms_pkg;

  typedef enum logic [`TMS_SEL_WIDTH-1:0] {
    MM_RESET, MM_ENABLE, MM_UPDATE, MM_CAPCMP, MM_OREF0, MM_OREF1, MM_OREF2, MM_OREF3
  } tms_master_type;

  typedef enum logic [`TMS_SEL_WIDTH-1:0] {
    SM_DISABLE, SM_QUAD1, SM_QUAD2, SM_QUAD3, SM_RESTART, SM_PAUSE, SM_TRIGGER, SM_EDGE_CLOCK
  } tms_slave_type;

  typedef struct packed {
    tms_master_type master_source_select;
    tms_slave_type slave_behaviour_select;
    logic [`TMS_TRS_WIDTH-1:0] trigger_source_select;
    logic sync_delay_enable;
    logic update_event_suppress;
    logic count_down_mode;
    logic [`TMS_CNT_WIDTH-1:0] counter_reload_value;
  } tms_cfg_type;

  typedef struct packed {
    logic chan0_filtered;
    logic chan1_filtered;
    logic ext_trigger;
    logic chan0_edge;
    logic [2:0] internal_trigger;
  } tms_src_type;

  typedef struct packed {
    logic count_tick;
    logic count_down;
    logic reload;
    logic [`TMS_CNT_WIDTH-1:0] reload_value;
    logic counter_enable;
    logic update_event;
    logic prescaler_reinit;
  } tms_ctrl_type;

endpackage
`default_nettype wire

// ===== core/tms_quad_decode.sv
// Quadrature decoder for the two channel inputs
`default_nettype none

module tms_quad_decode import tms_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Mode and channel inputs
  input wire tms_slave_type i_mode,
  input wire logic i_chan0_input,
  input wire logic i_chan1_input,
  // Count pulse and direction
  output logic o_tick,
  output logic o_down
);

  typedef struct packed {
    logic c0;
    logic c1;
    logic tick;
    logic down;
  } tms_qd_state_type;

  tms_qd_state_type s_q, s_d;
  logic e0, e1;

  always_comb begin
    s_d = s_q;
    e0 = i_chan0_input ^ s_q.c0;
    e1 = i_chan1_input ^ s_q.c1;
    s_d.c0 = i_chan0_input;
    s_d.c1 = i_chan1_input;
    s_d.tick = 1'b0;
    s_d.down = 1'b0;
    case (i_mode)
      SM_QUAD1: begin
        s_d.tick = e0; // RQ8
        s_d.down = i_chan0_input == i_chan1_input;
      end
      SM_QUAD2: begin
        s_d.tick = e1; // RQ9
        s_d.down = i_chan0_input != i_chan1_input;
      end
      SM_QUAD3: begin
        // Both edges at once carry no direction
        s_d.tick = e0 ^ e1; // RQ10
        s_d.down = e0 ? (i_chan0_input == i_chan1_input) : (i_chan0_input != i_chan1_input);
      end
      default: begin
        s_d.tick = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_q <= `TMS_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
  assign o_down = s_q.down;

endmodule // tms_quad_decode
`default_nettype wire

// ===== core/tms_sync.sv
// Master trigger and slave mode control of a general timer
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// [RQ1] A 3-bit master select picks the source of the master trigger output.
// [RQ2] Select 000: pulse on software update or slave restart trigger.
// [RQ3] Select 001: master trigger follows the counter enable.
// [RQ4] Select 010: master trigger carries update event when not suppressed.
// [RQ5] Select 011: pulse on each channel 0 capture or compare event.
// [RQ6] Selects 100 to 111: follow channel 0 to 3 output reference.
// [RQ7] Slave select 000: prescaler clocked by the internal clock.
// [RQ8] Slave 001: count on channel 0 edges, direction from channel 1 level.
// [RQ9] Slave 010: count on channel 1 edges, direction from channel 0 level.
// [RQ10] Slave 011: count on either channel edge, qualified by the other.
// [RQ11] Slave 100: trigger rise reloads zero or reload value, updates registers.
// [RQ12] Slave 101: count only while trigger high, hold value when low.
// [RQ13] Slave 110: trigger rise starts the counter; stopping is not controlled.
// [RQ14] Slave 111: each trigger rise is one count clock.
// [RQ15] Sync enable delays own actions to stay aligned with slaves.
// [RQ16] Trigger source select picks the slave trigger input.
// [RQ17] Suppression blocks update event but keeps prescaler reinitialisation.
// [RQ18] Event-derived master trigger outputs are one-cycle pulses.
module tms_sync import tms_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Configuration
  input wire tms_cfg_type i_cfg,
  input wire logic i_timer_enable,
  // Counter and channel events
  input wire logic i_update_generate_bit,
  input wire logic i_overflow,
  input wire logic i_chan0_ccev,
  input wire logic [3:0] i_chan_out_reference,
  // Slave trigger sources
  input wire tms_src_type i_src,
  // Quadrature inputs
  input wire logic i_chan0_input,
  input wire logic i_chan1_input,
  // Master trigger and counter control
  output logic o_master_trigger_out,
  output var tms_ctrl_type o_ctrl
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic ug;
    logic ovf;
    logic cc;
    logic slave_trigger_in;
    logic started;
    tms_ctrl_type dly;
    tms_ctrl_type out;
    logic master_trigger_out;
  } tms_state_type;

  tms_state_type s_q, s_d;

  logic q_tick;
  logic q_down;
  logic ug_p;
  logic ovf_p;
  logic cc_p;
  logic slave_trigger_in;
  logic sti_rise;
  logic restart;
  logic en;
  logic mto_now;
  tms_ctrl_type ctrl_now;

  function automatic logic trig_select(input logic [`TMS_TRS_WIDTH-1:0] sel, input logic sw,
                                       input tms_src_type src);
    logic r;
    r = 1'b0;
    if (sel == `TMS_TRS_SOFTWARE) begin
      r = sw;
    end else if (sel == `TMS_TRS_CHAN0_FILT) begin
      r = src.chan0_filtered;
    end else if (sel == `TMS_TRS_CHAN1_FILT) begin
      r = src.chan1_filtered;
    end else if (sel == `TMS_TRS_EXT_TRIG) begin
      r = src.ext_trigger;
    end else if (sel == `TMS_TRS_CHAN0_EDGE) begin
      r = src.chan0_edge;
    end else if (sel == `TMS_TRS_INTERNAL0) begin
      r = src.internal_trigger[0];
    end else if (sel == `TMS_TRS_INTERNAL1) begin
      r = src.internal_trigger[1];
    end else if (sel == `TMS_TRS_INTERNAL2) begin
      r = src.internal_trigger[2];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Quadrature decoding

  tms_quad_decode u_quad (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_mode(i_cfg.slave_behaviour_select),
    .i_chan0_input(i_chan0_input),
    .i_chan1_input(i_chan1_input),
    .o_tick(q_tick),
    .o_down(q_down)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    // Edge detect so held levels give single pulses
    ug_p = i_update_generate_bit & ~s_q.ug; // RQ18
    ovf_p = i_overflow & ~s_q.ovf;
    cc_p = i_chan0_ccev & ~s_q.cc; // RQ18
    slave_trigger_in = trig_select(i_cfg.trigger_source_select, ug_p, i_src); // RQ16
    sti_rise = slave_trigger_in & ~s_q.slave_trigger_in;
    restart = (i_cfg.slave_behaviour_select == SM_RESTART) & sti_rise; // RQ11
    ctrl_now = '0;
    en = i_timer_enable;
    s_d.started = 1'b0;
    case (i_cfg.slave_behaviour_select)
      SM_PAUSE: begin
        en = i_timer_enable & slave_trigger_in; // RQ12
        ctrl_now.count_tick = en;
      end
      SM_TRIGGER: begin
        // Latch holds until the timer itself is disabled
        s_d.started = i_timer_enable & (s_q.started | sti_rise); // RQ13
        en = s_d.started;
        ctrl_now.count_tick = en;
      end
      SM_QUAD1, SM_QUAD2, SM_QUAD3: begin
        ctrl_now.count_tick = en & q_tick; // RQ10
      end
      SM_EDGE_CLOCK: begin
        ctrl_now.count_tick = en & sti_rise; // RQ14
      end
      default: begin
        ctrl_now.count_tick = en; // RQ7
      end
    endcase
    ctrl_now.counter_enable = en;
    if ((i_cfg.slave_behaviour_select == SM_QUAD1) || (i_cfg.slave_behaviour_select == SM_QUAD2) ||
        (i_cfg.slave_behaviour_select == SM_QUAD3)) begin
      ctrl_now.count_down = q_down; // RQ8 RQ9
    end else begin
      ctrl_now.count_down = i_cfg.count_down_mode;
    end
    ctrl_now.reload = restart; // RQ11
    ctrl_now.reload_value = i_cfg.count_down_mode ? i_cfg.counter_reload_value : `TMS_RELOAD_ZERO;
    ctrl_now.update_event = (ovf_p | ug_p | restart) & ~i_cfg.update_event_suppress; // RQ17
    ctrl_now.prescaler_reinit = ug_p | restart; // RQ17
    case (i_cfg.master_source_select) // RQ1
      MM_RESET: begin
        mto_now = ug_p | restart; // RQ2
      end
      MM_ENABLE: begin
        mto_now = en; // RQ3
      end
      MM_UPDATE: begin
        mto_now = ctrl_now.update_event; // RQ4
      end
      MM_CAPCMP: begin
        mto_now = cc_p; // RQ5
      end
      default: begin
        mto_now = i_chan_out_reference[i_cfg.master_source_select[1:0]]; // RQ6
      end
    endcase
    s_d.ug = i_update_generate_bit;
    s_d.ovf = i_overflow;
    s_d.cc = i_chan0_ccev;
    s_d.slave_trigger_in = slave_trigger_in;
    s_d.master_trigger_out = mto_now;
    // Own actions wait one stage while slaves catch the trigger
    s_d.dly = ctrl_now;
    s_d.out = i_cfg.sync_delay_enable ? s_q.dly : ctrl_now; // RQ15
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      s_q <= `TMS_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_master_trigger_out = s_q.master_trigger_out;
  assign o_ctrl = s_q.out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  logic nodly;
  logic [1:0] oref_sel_now;
  logic quad_mode;
  logic refused_src;
  assign nodly = ~i_cfg.sync_delay_enable;
  assign oref_sel_now = i_cfg.master_source_select[1:0];
  assign quad_mode = (i_cfg.slave_behaviour_select == SM_QUAD1) || (i_cfg.slave_behaviour_select == SM_QUAD2) ||
                     (i_cfg.slave_behaviour_select == SM_QUAD3);
  // Source codes 4 to 7 and C to F
  assign refused_src = i_cfg.trigger_source_select[2];

  sequence s_cc_pulse;
    (i_cfg.master_source_select == MM_CAPCMP) ##1
    ((i_cfg.master_source_select == MM_CAPCMP) && o_master_trigger_out);
  endsequence

  a_master_reset_pulse: assert property ( // RQ2
    (i_cfg.master_source_select == MM_RESET) && (ug_p || restart) |=> o_master_trigger_out)
    else $error("reset mode trigger missing");

  a_master_enable_follow: assert property ( // RQ3
    (i_cfg.master_source_select == MM_ENABLE) |=> o_master_trigger_out == $past(en))
    else $error("enable mode trigger mismatch");

  a_master_update_gate: assert property ( // RQ4
    (i_cfg.master_source_select == MM_UPDATE) && i_cfg.update_event_suppress |=> !o_master_trigger_out)
    else $error("suppressed update reached trigger");

  a_update_carry: assert property ( // RQ4
    (i_cfg.master_source_select == MM_UPDATE) && !i_cfg.update_event_suppress && (ovf_p || ug_p || restart) |=>
    o_master_trigger_out)
    else $error("update event missing on trigger");

  a_capcmp_pulse_on: assert property ( // RQ5
    (i_cfg.master_source_select == MM_CAPCMP) && cc_p |=> o_master_trigger_out)
    else $error("capture trigger pulse missing");

  a_capcmp_single_pulse: assert property ( // RQ5
    s_cc_pulse |=> !o_master_trigger_out)
    else $error("capture trigger pulse too long");

  a_master_oref_follow: assert property ( // RQ6
    (i_cfg.master_source_select >= MM_OREF0) |=>
    o_master_trigger_out == $past(i_chan_out_reference[oref_sel_now[1:0]]))
    else $error("reference trigger mismatch");

  a_disable_tick: assert property ( // RQ7
    nodly && (i_cfg.slave_behaviour_select == SM_DISABLE) && i_timer_enable |=> o_ctrl.count_tick)
    else $error("internal clock tick missing");

  a_quad_tick_pass: assert property ( // RQ8 RQ9 RQ10
    nodly && quad_mode && i_timer_enable && q_tick |=> o_ctrl.count_tick && (o_ctrl.count_down == $past(q_down)))
    else $error("quadrature tick or direction lost");

  a_restart_reload: assert property ( // RQ11
    nodly && restart |=> o_ctrl.reload && o_ctrl.prescaler_reinit &&
    (o_ctrl.reload_value == $past(ctrl_now.reload_value)))
    else $error("restart reload wrong");

  a_pause_hold: assert property ( // RQ12
    nodly && (i_cfg.slave_behaviour_select == SM_PAUSE) && !slave_trigger_in |=>
    !o_ctrl.count_tick && !o_ctrl.counter_enable)
    else $error("pause mode kept counting");

  sequence s_trig_armed;
    nodly && (i_cfg.slave_behaviour_select == SM_TRIGGER) && i_timer_enable && sti_rise ##1
    nodly && (i_cfg.slave_behaviour_select == SM_TRIGGER) && i_timer_enable;
  endsequence

  a_trigger_start: assert property ( // RQ13
    s_trig_armed |-> o_ctrl.counter_enable [*2])
    else $error("trigger mode did not start");

  a_trigger_hold: assert property ( // RQ13
    nodly && (i_cfg.slave_behaviour_select == SM_TRIGGER) && s_q.started && i_timer_enable |=>
    o_ctrl.counter_enable)
    else $error("trigger mode stopped without disable");

  a_edge_clock_tick: assert property ( // RQ14
    nodly && (i_cfg.slave_behaviour_select == SM_EDGE_CLOCK) && i_timer_enable && sti_rise |=>
    o_ctrl.count_tick)
    else $error("edge clock tick missing");

  a_edge_clock_idle: assert property ( // RQ14
    nodly && (i_cfg.slave_behaviour_select == SM_EDGE_CLOCK) && !sti_rise |=> !o_ctrl.count_tick)
    else $error("edge clock tick without trigger rise");

  a_refused_source: assert property ( // RQ16
    refused_src |-> !slave_trigger_in)
    else $error("refused trigger source drove trigger");

  a_sync_delay_on: assert property ( // RQ15
    i_cfg.sync_delay_enable |=> o_ctrl == $past(ctrl_now, 2))
    else $error("sync delay not applied");

  a_sync_delay_off: assert property ( // RQ15
    nodly |=> o_ctrl == $past(ctrl_now))
    else $error("delay added without sync enable");

  a_suppress_reinit: assert property ( // RQ17
    nodly && i_cfg.update_event_suppress && ug_p |=> o_ctrl.prescaler_reinit && !o_ctrl.update_event)
    else $error("suppression handling wrong");

endmodule // tms_sync
`default_nettype wire

// ===== verification/tms_peer_timer.sv
// Peer timer model that holds an internal trigger level for a set count
`default_nettype none

module tms_peer_timer (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Start request and length
  input wire logic i_start,
  input wire logic [3:0] i_len,
  // Trigger level towards the slave
  output logic o_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] count_q;
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      count_q <= 4'h0;
    end else if (i_start) begin
      count_q <= i_len;
    end else if (count_q != 4'h0) begin
      count_q <= count_q - 4'h1;
    end
  end
  // Level drops to idle low once the count runs out
  assign o_trigger = (count_q != 4'h0);
endmodule // tms_peer_timer

`default_nettype wire

// ===== verification/tb_tms_sync.sv
// Self-checking bench of the timer master/slave synchronisation block
`default_nettype none
`include "tms_params.svh"

module tb_tms_sync import tms_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic kind;
    logic [15:0] mask;
    logic [15:0] exp;
  } tms_note_type;
  logic clock, resetn, ten, ug, ovf, ccev, c0, c1, ext, start, trig, master_trigger_out;
  logic [3:0] refs;
  logic [3:0] len;
  logic [6:0] obs;
  tms_cfg_type cfg;
  tms_src_type src;
  tms_ctrl_type ctrl;
  tms_note_type notes[$];
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Filtered, external and edge sources all follow one stimulus
  assign src = {ext, ext, ext, ext, {3{trig}}};
  assign obs = {ctrl.count_down, master_trigger_out, ctrl.count_tick, ctrl.reload, ctrl.counter_enable, ctrl.update_event,
                ctrl.prescaler_reinit};

  tms_sync dut (
    .i_clock(clock), .i_resetn(resetn), .i_cfg(cfg), .i_timer_enable(ten),
    .i_update_generate_bit(ug), .i_overflow(ovf), .i_chan0_ccev(ccev), .i_chan_out_reference(refs),
    .i_src(src), .i_chan0_input(c0), .i_chan1_input(c1), .o_master_trigger_out(master_trigger_out), .o_ctrl(ctrl)
  );
  tms_peer_timer peer (.i_clock(clock), .i_resetn(resetn), .i_start(start), .i_len(len), .o_trigger(trig));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic cmp_flags(input logic [6:0] m, input logic [6:0] e);
    samples_checked++;
    if ((obs & m) !== e) begin
      miscompares++;
      $display("Error t=%0t flags got %h exp %h", $time, obs & m, e);
    end
  endtask

  task automatic cmp_value(input logic [15:0] e);
    samples_checked++;
    if (ctrl.reload_value !== e) begin
      miscompares++;
      $display("Error t=%0t reload value got %h exp %h", $time, ctrl.reload_value, e);
    end
  endtask

  // Notes pushed at a falling edge are judged at the next rising edge
  always @(posedge clock) begin : monitor
    tms_note_type n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      if (n.kind) cmp_value(n.exp);
      else cmp_flags(n.mask[6:0], n.exp[6:0]);
    end
  end

  task automatic xf(input logic [5:0] m, input logic [5:0] e);
    notes.push_back('{1'b0, {10'h000, m}, {10'h000, e}});
  endtask

  task automatic xd(input logic e);
    notes.push_back('{1'b0, 16'h0040, {9'h000, e, 6'h00}});
  endtask

  task automatic xv(input logic [15:0] e);
    notes.push_back('{1'b1, 16'hFFFF, e});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic summarize();
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    int j;
    int d;
    int s;
    logic [15:0] rv;
    cfg = '0;
    {ten, ug, ovf, ccev, c0, c1, ext, start} = 8'h00;
    refs = 4'h0;
    len = 4'h3;
    resetn = 1'b0;
    rv = 16'($urandom(41667));
    step(8);
    resetn = 1'b1;
    step(2);
    for (k = 0; k < 4; k++) begin
      cfg.master_source_select = tms_master_type'(3'h4 + 3'(k));
      for (j = 0; j < 2; j++) begin
        refs = 4'($urandom);
        refs[k] = j[0];
        step(1);
        xf(6'h20, {refs[k], 5'h00});
      end
    end
    done("reference");
    cfg.master_source_select = MM_ENABLE;
    ten = 1'b1;
    step(3);
    xf(6'h34, 6'h34);
    ten = 1'b0;
    step(3);
    xf(6'h34, 6'h00);
    done("enable");
    for (k = 0; k < 4; k++) begin
      cfg.master_source_select = (k == 0) ? MM_RESET : (k == 3) ? MM_CAPCMP : MM_UPDATE;
      cfg.update_event_suppress = (k == 2);
      step(1);
      {ccev, ovf, ug} = (k == 0 || k == 2) ? 3'h1 : (k == 3) ? 3'h4 : 3'h2;
      step(1);
      xf(6'h23, {(k != 2), 3'h0, (k < 2), (k == 0 || k == 2)});
      step(1);
      xf(6'h23, 6'h00);
      {ccev, ovf, ug} = 3'h0;
      step(1);
    end
    done("events");
    cfg.master_source_select = MM_RESET;
    cfg.slave_behaviour_select = SM_RESTART;
    cfg.trigger_source_select = `TMS_TRS_EXT_TRIG;
    for (d = 0; d < 2; d++) begin
      for (s = 0; s < 2; s++) begin
        cfg.sync_delay_enable = d[0];
        cfg.update_event_suppress = s[0];
        cfg.count_down_mode = 1'($urandom);
        cfg.counter_reload_value = 16'($urandom);
        case (2 * d + s)
          0: cfg.trigger_source_select = `TMS_TRS_CHAN0_FILT;
          1: cfg.trigger_source_select = `TMS_TRS_CHAN1_FILT;
          2: cfg.trigger_source_select = `TMS_TRS_EXT_TRIG;
          default: cfg.trigger_source_select = `TMS_TRS_CHAN0_EDGE;
        endcase
        rv = cfg.count_down_mode ? cfg.counter_reload_value : 16'h0000;
        step(1);
        ext = 1'b1;
        step(1);
        xf(6'h20, 6'h20);
        if (d == 1) begin
          xf(6'h0B, 6'h00);
          step(1);
        end
        xf(6'h0B, {4'h2, !s[0], 1'b1});
        xv(rv);
        step(1);
        xf(6'h2B, 6'h00);
        ext = 1'b0;
        step(1);
      end
    end
    cfg.sync_delay_enable = 1'b0;
    cfg.update_event_suppress = 1'b0;
    done("restart");
    cfg.slave_behaviour_select = SM_PAUSE;
    cfg.trigger_source_select = 4'(4'h9 + $urandom_range(2));
    ten = 1'b1;
    step(2);
    start = 1'b1;
    step(1);
    start = 1'b0;
    for (j = 1; j < 6; j++) begin
      xf(6'h14, (j >= 2 && j <= 4) ? 6'h14 : 6'h00);
      step(1);
    end
    done("pause");
    cfg.slave_behaviour_select = SM_TRIGGER;
    cfg.trigger_source_select = `TMS_TRS_EXT_TRIG;
    step(2);
    xf(6'h04, 6'h00);
    ext = 1'b1;
    step(1);
    xf(6'h14, 6'h14);
    ext = 1'b0;
    step(3);
    xf(6'h14, 6'h14);
    ten = 1'b0;
    step(2);
    xf(6'h04, 6'h00);
    done("trigger");
    cfg.slave_behaviour_select = SM_EDGE_CLOCK;
    ten = 1'b1;
    step(2);
    for (j = 0; j < 3; j++) begin
      ext = 1'b1;
      step(1);
      xf(6'h10, 6'h10);
      step(1);
      xf(6'h10, 6'h00);
      ext = 1'b0;
      step(1);
    end
    done("edge clock");
    cfg.trigger_source_select = 4'(4'h4 + $urandom_range(3));
    ext = 1'b1;
    step(1);
    xf(6'h10, 6'h00);
    ext = 1'b0;
    cfg.slave_behaviour_select = SM_RESTART;
    cfg.trigger_source_select = `TMS_TRS_SOFTWARE;
    ug = 1'b1;
    step(1);
    xf(6'h29, 6'h29);
    ug = 1'b0;
    step(1);
    done("sources");
    for (k = 1; k < 4; k++) begin
      cfg.slave_behaviour_select = tms_slave_type'(3'(k));
      {c0, c1} = 2'($urandom);
      step(3);
      for (j = 0; j < 2; j++) begin
        if (j == 0) c0 = !c0;
        else c1 = !c1;
        step(2);
        xf(6'h10, (k == 3 || k == j + 1) ? 6'h10 : 6'h00);
        if (k == 3 || k == j + 1) xd((j == 0) ? (c0 == c1) : (c0 != c1));
        step(2);
      end
    end
    done("quadrature");
    step(2);
    summarize();
  end
endmodule // tb_tms_sync

`default_nettype wire
